// ### remote_message_formatter.sv
// remote message parser and measurement record formatter
`timescale 1ns/10ps
`include "rmf_defines.svh"
module remote_message_formatter import rmf_pkg::*; #(
	parameter int BAUD_DIV = `BAUD_DIV
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    rxd,
	output logic                         txd,
	input  wire logic                    gpib_rx_valid,
	input  wire logic [7:0]              gpib_rx_data,
	input  wire logic                    gpib_rx_eoi,
	output logic                         gpib_tx_valid,
	output logic [7:0]                   gpib_tx_data,
	output logic                         gpib_tx_eoi,
	input  wire logic                    gpib_tx_ready,
	input  wire logic [4:0]              addr_setting,
	output logic [4:0]                   gpib_addr,
	output logic                         remote_en,
	input  wire logic                    cmp_enable,
	output logic                         meas_trigger,
	input  wire logic                    meas_ready,
	input  wire chan_rec_t [`NUM_CH-1:0] chan_data,
	output logic                         msg_strobe,
	output logic [31:0]                  msg_header,
	output logic                         msg_query,
	output logic [7:0]                   msg_arg,
	output logic                         syntax_err
);
	fmtr_st_t    st_ff, nxt_st;
	logic        ser_valid;
	logic [7:0]  ser_byte;
	logic        ser_ready;
	logic        in_valid;
	logic        in_ser;
	logic        in_eoi;
	logic [7:0]  in_byte;
	logic        is_sep;
	logic        term_now;
	logic        add_hdr;
	logic        add_arg;
	logic [31:0] hdr_fin;
	logic [2:0]  len_fin;
	logic        over_fin;
	logic [7:0]  arg_fin;
	logic        has_fin;
	logic        arg_ok;
	logic        is_query;
	logic        tx_ready;
	logic        load_ok;
	logic        last_ch;
	chan_rec_t   cur;
	logic [7:0]  exp_over;

	// -----------------------------------------------------------------
	// serial line
	// -----------------------------------------------------------------
	serial_rx_unit #(.DIV(BAUD_DIV)) u_rx (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.rxd      (rxd),
		.rx_valid (ser_valid),
		.rx_byte  (ser_byte)
	);

	serial_tx_unit #(.DIV(BAUD_DIV)) u_tx (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.tx_valid (st_ff.ov && st_ff.reply_ser),
		.tx_byte  (st_ff.ob),
		.tx_ready (ser_ready),
		.txd      (txd)
	);

	// -----------------------------------------------------------------
	// record character helpers
	// -----------------------------------------------------------------
	function automatic logic [7:0] digit(input logic [3:0] d, input chan_rec_t c);
		if (c.over_range)
			return c.is_current ? `CH_ZERO : `CH_NINE;
		return `CH_ZERO + {4'h0, d};
	endfunction

	function automatic logic [7:0] sign_ch(input logic neg);
		return neg ? `CH_MINUS : `CH_PLUS;
	endfunction

	function automatic logic pos_on(input logic [4:0] p, input record_fmt_t f, input logic ce);
		if (p >= `POS_VAL_FIRST && p <= `POS_VAL_LAST)
			return f != FMT_CMP;
		if (p > `POS_VAL_LAST && p <= `POS_STAT)
			return f == FMT_BASIC;
		if (p > `POS_STAT && p <= `POS_CMP)
			return ce && f != FMT_VALUE;
		return 1'b1;
	endfunction

	function automatic logic [4:0] last_pos(input record_fmt_t f, input logic ce);
		if (ce && f != FMT_VALUE)
			return `POS_CMP;
		if (f == FMT_BASIC)
			return `POS_STAT;
		if (f == FMT_VALUE)
			return `POS_VAL_LAST;
		return `POS_CH;
	endfunction

	// field order: channel, value, status, comparison
	function automatic logic [7:0] char_at(input logic [4:0] p, input logic [2:0] ch,
			input chan_rec_t c);
		case (p)
			`POS_CH: char_at = `CH_ONE + {5'h00, ch};
			5'h02:   char_at = sign_ch(c.neg);
			5'h03:   char_at = digit(c.mant[19:16], c);
			5'h04:   char_at = `CH_DOT;
			5'h05:   char_at = digit(c.mant[15:12], c);
			5'h06:   char_at = digit(c.mant[11:8], c);
			5'h07:   char_at = digit(c.mant[7:4], c);
			5'h08:   char_at = digit(c.mant[3:0], c);
			5'h09:   char_at = `CH_EXP;
			5'h0a:   char_at = sign_ch(c.exp_neg);
			5'h0b:   char_at = digit(c.expo[7:4], c);
			`POS_VAL_LAST: char_at = digit(c.expo[3:0], c);
			`POS_STAT: char_at = `CH_ZERO + {5'h00, c.over_range, c.contact_err, 1'b0};
			`POS_CMP: char_at = c.above_hi ? `CH_ZERO : (c.below_lo ? `CH_TWO : `CH_ONE);
			default: char_at = `CH_COMMA;
		endcase
	endfunction

	// -----------------------------------------------------------------
	// input byte steering and message assembly
	// -----------------------------------------------------------------
	assign in_valid = gpib_rx_valid || ser_valid;
	assign in_ser = !gpib_rx_valid;
	assign in_byte = gpib_rx_valid ? gpib_rx_data : ser_byte;
	assign in_eoi = gpib_rx_valid && gpib_rx_eoi;
	assign is_sep = in_byte == `CH_CR || in_byte == `CH_LF || in_byte == `CH_SEMI;
	assign term_now = in_valid && (is_sep || in_eoi);
	assign add_hdr = in_valid && !is_sep && !st_ff.in_data && in_byte != `CH_SP;
	assign hdr_fin = (add_hdr && st_ff.hdr_len != 3'h4) ? {st_ff.hdr[23:0], in_byte} : st_ff.hdr;
	assign len_fin = (add_hdr && st_ff.hdr_len != 3'h4) ? st_ff.hdr_len + 3'h1 : st_ff.hdr_len;
	assign over_fin = st_ff.hdr_over || (add_hdr && st_ff.hdr_len == 3'h4);
	assign add_arg = in_valid && !is_sep && st_ff.in_data && !st_ff.has_arg;
	assign arg_fin = add_arg ? in_byte : st_ff.arg;
	assign has_fin = st_ff.has_arg || add_arg;
	assign arg_ok = has_fin && arg_fin >= `CH_ZERO && arg_fin <= `CH_TWO;
	assign is_query = hdr_fin[7:0] == `CH_QM;
	assign tx_ready = st_ff.reply_ser ? ser_ready : gpib_tx_ready;
	assign load_ok = !st_ff.ov || tx_ready;
	assign last_ch = st_ff.ch == 3'(`NUM_CH - 1);
	assign cur = st_ff.snap[st_ff.ch];
	assign exp_over = cur.is_current ? `CH_ZERO : `CH_NINE;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.msg_stb = 1'b0;
		nxt_st.syn_err = 1'b0;
		nxt_st.trig = 1'b0;
		if (!st_ff.addr_loaded) begin
			// address read once after each reset only
			nxt_st.addr_loaded = 1'b1;
			if (addr_setting >= `ADDR_MIN && addr_setting <= `ADDR_MAX)
				nxt_st.addr = addr_setting;
		end
		if (st_ff.ov && tx_ready)
			nxt_st.ov = 1'b0;
		if (in_valid) begin
			nxt_st.hdr = hdr_fin;
			nxt_st.hdr_len = len_fin;
			nxt_st.hdr_over = over_fin;
			nxt_st.arg = arg_fin;
			nxt_st.has_arg = has_fin;
			if (!is_sep && !st_ff.in_data && in_byte == `CH_SP)
				nxt_st.in_data = 1'b1;
		end
		if (term_now) begin
			nxt_st.hdr = 32'h00000000;
			nxt_st.hdr_len = 3'h0;
			nxt_st.hdr_over = 1'b0;
			nxt_st.in_data = 1'b0;
			nxt_st.has_arg = 1'b0;
			nxt_st.arg = 8'h00;
			if (len_fin == 3'h0 && !over_fin) begin
				// empty message, e.g. lf after cr
			end else if (in_ser && !st_ff.remote_en) begin
				if (hdr_fin == `HDR_REMOTE)
					nxt_st.remote_en = 1'b1;
			end else if (over_fin) begin
				nxt_st.syn_err = 1'b1;
			end else if (hdr_fin == `HDR_REMOTE) begin
				nxt_st.remote_en = in_ser || st_ff.remote_en;
			end else if (hdr_fin == `HDR_DELIM || hdr_fin == `HDR_FORMAT) begin
				if (!arg_ok)
					nxt_st.syn_err = 1'b1;
				else if (hdr_fin == `HDR_DELIM)
					nxt_st.term = resp_term_t'(arg_fin[1:0]);
				else
					nxt_st.fmt = record_fmt_t'(arg_fin[1:0]);
			end else if (hdr_fin == `HDR_TRIG || hdr_fin == `HDR_READ) begin
				if (st_ff.fsm != S_IDLE || has_fin) begin
					nxt_st.syn_err = 1'b1;
				end else begin
					nxt_st.reply_ser = in_ser;
					nxt_st.ch = 3'h0;
					nxt_st.pos = `POS_CH;
					if (hdr_fin == `HDR_TRIG) begin
						nxt_st.fsm = S_WAIT;
						nxt_st.trig = 1'b1;
					end else begin
						nxt_st.fsm = S_EMIT;
						nxt_st.snap = chan_data;
					end
				end
			end else begin
				nxt_st.msg_stb = 1'b1;
				nxt_st.msg_hdr = hdr_fin;
				nxt_st.msg_q = is_query;
				nxt_st.msg_arg = has_fin ? arg_fin : 8'h00;
			end
		end
		case (st_ff.fsm)
			S_IDLE: begin
			end
			S_WAIT: begin
				if (meas_ready) begin
					nxt_st.fsm = S_EMIT;
					nxt_st.snap = chan_data;
				end
			end
			S_EMIT: begin
				if (load_ok) begin
					if (st_ff.pos == `POS_NEXT) begin
						if (last_ch) begin
							nxt_st.fsm = S_TERM;
						end else begin
							nxt_st.ob = `CH_COMMA;
							nxt_st.ov = 1'b1;
							nxt_st.oe = 1'b0;
							nxt_st.ch = st_ff.ch + 3'h1;
							nxt_st.pos = `POS_CH;
						end
					end else begin
						if (pos_on(st_ff.pos, st_ff.fmt, cmp_enable)) begin
							nxt_st.ob = char_at(st_ff.pos, st_ff.ch, cur);
							nxt_st.ov = 1'b1;
							nxt_st.oe = st_ff.term == RT_EOI && last_ch &&
								st_ff.pos == last_pos(st_ff.fmt, cmp_enable);
						end
						nxt_st.pos = st_ff.pos + 5'h01;
					end
				end
			end
			S_TERM: begin
				if (load_ok) begin
					nxt_st.fsm = S_IDLE;
					if (st_ff.term == RT_CRLF) begin
						nxt_st.ob = `CH_CR;
						nxt_st.ov = 1'b1;
						nxt_st.oe = 1'b0;
						nxt_st.fsm = S_TERM2;
					end else if (st_ff.term == RT_LF) begin
						nxt_st.ob = `CH_LF;
						nxt_st.ov = 1'b1;
						nxt_st.oe = 1'b1;
					end
				end
			end
			S_TERM2: begin
				if (load_ok) begin
					nxt_st.ob = `CH_LF;
					nxt_st.ov = 1'b1;
					nxt_st.oe = 1'b1;
					nxt_st.fsm = S_IDLE;
				end
			end
			default: begin
				nxt_st.fsm = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.fsm <= S_IDLE;
			st_ff.addr <= `ADDR_RST;
			st_ff.term <= resp_term_t'(`TERM_RST);
			st_ff.fmt <= record_fmt_t'(`FMT_RST);
		end else begin
			st_ff <= nxt_st;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign gpib_tx_valid = st_ff.ov && !st_ff.reply_ser;
	assign gpib_tx_data = st_ff.ob;
	assign gpib_tx_eoi = st_ff.oe;
	assign gpib_addr = st_ff.addr;
	assign remote_en = st_ff.remote_en;
	assign meas_trigger = st_ff.trig;
	assign msg_strobe = st_ff.msg_stb;
	assign msg_header = st_ff.msg_hdr;
	assign msg_query = st_ff.msg_q;
	assign msg_arg = st_ff.msg_arg;
	assign syntax_err = st_ff.syn_err;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_addr_range:
	assert property (gpib_addr >= `ADDR_MIN && gpib_addr <= `ADDR_MAX)
		else $error("bus address out of range");
	a_addr_hold:
	assert property (st_ff.addr_loaded |=> $stable(gpib_addr))
		else $error("bus address changed after power-on");
	a_serial_gate:
	assert property ((term_now && in_ser && !remote_en && hdr_fin != `HDR_REMOTE)
		|=> !msg_strobe && !meas_trigger && !remote_en) else $error("serial message not ignored");
	a_query_class:
	assert property (msg_strobe |-> msg_query == (msg_header[7:0] == `CH_QM))
		else $error("query classification wrong");
	a_term_clear:
	assert property ((term_now && len_fin != 3'h0) |=> st_ff.hdr_len == 3'h0 && !st_ff.in_data)
		else $error("terminator did not end message");
	a_term_select:
	assert property ((term_now && hdr_fin == `HDR_DELIM && arg_ok && !over_fin && !in_ser)
		|=> {6'h00, st_ff.term} == $past(arg_fin) - `CH_ZERO) else $error("terminator not selected");
	a_meas_start:
	assert property ((st_ff.fsm == S_WAIT && meas_ready)
		|=> st_ff.fsm == S_EMIT && st_ff.ch == 3'h0 && st_ff.pos == `POS_CH)
		else $error("record did not start after measurement");
	a_chan_digit:
	assert property ((st_ff.fsm == S_EMIT && load_ok && st_ff.pos == `POS_CH)
		|=> st_ff.ov && st_ff.ob == `CH_ONE + {5'h00, $past(st_ff.ch)})
		else $error("channel digit wrong");
	a_over_digit:
	assert property ((st_ff.fsm == S_EMIT && load_ok && st_ff.pos == 5'h03 && cur.over_range &&
		st_ff.fmt != FMT_CMP) |=> st_ff.ob == $past(exp_over)) else $error("over range digit wrong");
	a_status_digit:
	assert property ((st_ff.fsm == S_EMIT && load_ok && st_ff.pos == `POS_STAT &&
		st_ff.fmt == FMT_BASIC) |=> !st_ff.ob[0] && st_ff.ob <= `CH_ZERO + 8'h06)
		else $error("status digit wrong");
	a_lf_end:
	assert property ((st_ff.fsm == S_TERM && load_ok && st_ff.term == RT_LF)
		|=> st_ff.ov && st_ff.ob == `CH_LF && st_ff.oe) else $error("lf terminator missing");
	a_crlf_end:
	assert property ((st_ff.fsm == S_TERM && load_ok && st_ff.term == RT_CRLF)
		|=> st_ff.ob == `CH_CR ##[1:1000] (st_ff.ov && st_ff.ob == `CH_LF))
		else $error("cr lf terminator missing");

	c_record_lf: cover property (st_ff.fsm == S_TERM && load_ok && st_ff.term == RT_LF);
	c_record_crlf: cover property (st_ff.fsm == S_TERM2 && load_ok);
	c_query_out: cover property (msg_strobe && msg_query);
	c_remote_on: cover property ($rose(remote_en));
endmodule

// ### rmf_defines.svh
// constants of the remote message formatter
`ifndef RMF_DEFINES_SVH
`define RMF_DEFINES_SVH
`define CLK_HZ        20000000
`define BAUD_RATE     38400
`define BAUD_DIV      ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define NUM_CH        8
`define ADDR_MIN      5'h01
`define ADDR_MAX      5'h1e
`define ADDR_RST      5'h01
`define TERM_RST      2'h0
`define FMT_RST       2'h0
`define CH_LF         8'h0a
`define CH_CR         8'h0d
`define CH_SP         8'h20
`define CH_PLUS       8'h2b
`define CH_COMMA      8'h2c
`define CH_MINUS      8'h2d
`define CH_DOT        8'h2e
`define CH_ZERO       8'h30
`define CH_ONE        8'h31
`define CH_TWO        8'h32
`define CH_NINE       8'h39
`define CH_SEMI       8'h3b
`define CH_QM         8'h3f
`define CH_EXP        8'h45
`define HDR_REMOTE    32'h00524d54
`define HDR_DELIM     32'h00444c4d
`define HDR_TRIG      32'h004d5447
`define HDR_READ      32'h5244543f
`define HDR_FORMAT    32'h00464d54
`define POS_CH        5'h00
`define POS_VAL_FIRST 5'h01
`define POS_VAL_LAST  5'h0c
`define POS_STAT      5'h0e
`define POS_CMP       5'h10
`define POS_NEXT      5'h11
`endif

// ### rmf_pkg.sv
// types shared by the remote message formatter blocks
`include "rmf_defines.svh"
package rmf_pkg;
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_WAIT  = 5'h02,
		S_EMIT  = 5'h04,
		S_TERM  = 5'h08,
		S_TERM2 = 5'h10
	} fsm_t;
	typedef enum logic [1:0] {RT_LF = 2'h0, RT_CRLF = 2'h1, RT_EOI = 2'h2} resp_term_t;
	typedef enum logic [1:0] {FMT_BASIC = 2'h0, FMT_VALUE = 2'h1, FMT_CMP = 2'h2} record_fmt_t;
	typedef struct packed {
		logic        neg;
		logic [19:0] mant;
		logic        exp_neg;
		logic [7:0]  expo;
		logic        over_range;
		logic        is_current;
		logic        contact_err;
		logic        above_hi;
		logic        below_lo;
	} chan_rec_t;
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        busy;
		logic        done;
		logic [3:0]  bitn;
		logic [15:0] cnt;
		logic [9:0]  sh;
	} ser_st_t;
	typedef struct packed {
		fsm_t                       fsm;
		logic                       remote_en;
		logic                       addr_loaded;
		logic [4:0]                 addr;
		resp_term_t                 term;
		record_fmt_t                fmt;
		logic [31:0]                hdr;
		logic [2:0]                 hdr_len;
		logic                       hdr_over;
		logic                       in_data;
		logic [7:0]                 arg;
		logic                       has_arg;
		logic                       reply_ser;
		logic [2:0]                 ch;
		logic [4:0]                 pos;
		logic [7:0]                 ob;
		logic                       ov;
		logic                       oe;
		logic                       msg_stb;
		logic [31:0]                msg_hdr;
		logic                       msg_q;
		logic [7:0]                 msg_arg;
		logic                       syn_err;
		logic                       trig;
		chan_rec_t [`NUM_CH-1:0]    snap;
	} fmtr_st_t;
endpackage

// ### serial_rx_unit.sv
// serial byte receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/10ps
`include "rmf_defines.svh"
module serial_rx_unit import rmf_pkg::*; #(
	parameter int DIV = `BAUD_DIV
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rxd,
	output logic            rx_valid,
	output logic [7:0]      rx_byte
);
	ser_st_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = rxd;
		nxt_st.s2 = st_ff.s1;
		nxt_st.done = 1'b0;
		if (!st_ff.busy) begin
			if (!st_ff.s2) begin
				nxt_st.busy = 1'b1;
				nxt_st.cnt = 16'(DIV / 2);
				nxt_st.bitn = 4'h0;
			end
		end else if (st_ff.cnt != 16'h0000) begin
			nxt_st.cnt = st_ff.cnt - 16'h0001;
		end else begin
			// sample mid-bit, lsb first, stop bit must be high
			nxt_st.cnt = 16'(DIV - 1);
			nxt_st.sh = {st_ff.s2, st_ff.sh[9:1]};
			nxt_st.bitn = st_ff.bitn + 4'h1;
			if (st_ff.bitn == 4'h0 && st_ff.s2)
				nxt_st.busy = 1'b0;
			if (st_ff.bitn == 4'h9) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = st_ff.s2;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.s1 <= 1'b1;
			st_ff.s2 <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rx_valid = st_ff.done;
	assign rx_byte = st_ff.sh[8:1];
endmodule

// ### serial_tx_unit.sv
// serial byte transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/10ps
`include "rmf_defines.svh"
module serial_tx_unit import rmf_pkg::*; #(
	parameter int DIV = `BAUD_DIV
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output logic            tx_ready,
	output logic            txd
);
	ser_st_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (!st_ff.busy) begin
			if (tx_valid) begin
				nxt_st.busy = 1'b1;
				nxt_st.sh = {1'b1, tx_byte, 1'b0};
				nxt_st.cnt = 16'(DIV - 1);
				nxt_st.bitn = 4'h0;
			end
		end else if (st_ff.cnt != 16'h0000) begin
			nxt_st.cnt = st_ff.cnt - 16'h0001;
		end else begin
			nxt_st.cnt = 16'(DIV - 1);
			nxt_st.sh = {1'b1, st_ff.sh[9:1]};
			nxt_st.bitn = st_ff.bitn + 4'h1;
			if (st_ff.bitn == 4'h9)
				nxt_st.busy = 1'b0;
		end
		nxt_st.s1 = nxt_st.busy ? nxt_st.sh[0] : 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.s1 <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tx_ready = !st_ff.busy;
	assign txd = st_ff.s1;

	a_tx_start:
	assert property (@(posedge sys_clk) disable iff (rst)
		(tx_valid && tx_ready) |=> !txd [*8]) else $error("start bit not driven low");
	a_tx_stop:
	assert property (@(posedge sys_clk) disable iff (rst)
		(st_ff.busy && st_ff.bitn == 4'h9) |-> txd) else $error("stop bit not high");
endmodule

// ### host_model.sv
// host controller model on the parallel bus side
`timescale 1ns/10ps
module host_model (
	input  wire logic       sys_clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_eoi,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_eoi,
	output logic            tx_ready
);
	string got = "";
	logic  last_eoi = 1'b0;
	logic  slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_eoi = 1'b0;
		tx_ready = 1'b0;
	end
	// one byte per cycle, eoi optionally on the last one
	task automatic send(input string s, input logic e);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge sys_clk);
			rx_valid = 1'b1;
			rx_data = s[i];
			rx_eoi = e && (i == s.len() - 1);
		end
		@(negedge sys_clk);
		rx_valid = 1'b0;
		rx_eoi = 1'b0;
		rx_data = ~rx_data;
	endtask
	// slow mode takes a byte only every other cycle
	always @(negedge sys_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
	always @(posedge sys_clk) begin
		if (tx_valid && tx_ready) begin
			got = {got, string'(tx_data)};
			last_eoi = tx_eoi;
		end
	end
endmodule

// ### remote_message_formatter_tb.sv
// self-checking bench of the remote message formatter
`timescale 1ns/10ps
`include "rmf_defines.svh"
module remote_message_formatter_tb import rmf_pkg::*;;
	localparam int DIV = 8;
	logic sys_clk = 1'b0, rst = 1'b1, rxd = 1'b1, txd, cmp_enable = 1'b1, meas_ready = 1'b0;
	logic gpib_rx_valid, gpib_rx_eoi, gpib_tx_valid, gpib_tx_eoi, gpib_tx_ready;
	logic [7:0] gpib_rx_data, gpib_tx_data, msg_arg, arg_seen;
	logic [4:0] addr_setting = 5'h07, gpib_addr;
	logic remote_en, meas_trigger, msg_strobe, msg_query, syntax_err;
	logic [31:0] msg_header, hdr_seen;
	logic [7:0] sb;
	string sgot = "", sexp;
	chan_rec_t [`NUM_CH-1:0] chan_data = '0;
	int err_total = 0, compares = 0, nstb = 0, nq = 0, nerr = 0, ntrig = 0, n0;
	remote_message_formatter #(.BAUD_DIV(DIV)) DUT (.sys_clk, .rst, .rxd, .txd,
		.gpib_rx_valid, .gpib_rx_data, .gpib_rx_eoi, .gpib_tx_valid, .gpib_tx_data,
		.gpib_tx_eoi, .gpib_tx_ready, .addr_setting, .gpib_addr, .remote_en, .cmp_enable,
		.meas_trigger, .meas_ready, .chan_data, .msg_strobe, .msg_header, .msg_query,
		.msg_arg, .syntax_err);
	host_model host (.sys_clk, .rx_valid(gpib_rx_valid), .rx_data(gpib_rx_data),
		.rx_eoi(gpib_rx_eoi), .tx_valid(gpib_tx_valid), .tx_data(gpib_tx_data),
		.tx_eoi(gpib_tx_eoi), .tx_ready(gpib_tx_ready));
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (msg_strobe) begin
			nstb++;
			hdr_seen = msg_header;
			nq += msg_query;
			if (!msg_query)
				arg_seen = msg_arg;
		end
		if (syntax_err)
			nerr++;
		if (meas_trigger)
			ntrig++;
	end
	// serial reply receiver, samples each bit in its middle
	initial forever begin
		@(negedge txd);
		repeat (DIV / 2) @(negedge sys_clk);
		for (int k = 0; k < 8; k++) begin
			repeat (DIV) @(negedge sys_clk);
			sb[k] = txd;
		end
		repeat (DIV) @(negedge sys_clk);
		sgot = {sgot, string'(sb)};
	end
	// measurement finishes a few cycles after each trigger
	initial forever begin
		@(posedge sys_clk iff meas_trigger);
		repeat (4) @(negedge sys_clk);
		meas_ready = 1'b1;
		@(negedge sys_clk);
		meas_ready = 1'b0;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (e !== g) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chks(input string n, e, g);
		compares++;
		if (e != g) begin
			err_total++;
			$display("wrong value %s expected %s seen %s", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// header word to its characters, every zero byte dropped
	function automatic string hs(logic [31:0] h);
		string s = "";
		for (int i = 3; i >= 0; i--)
			if (h[i*8 +: 8] != 8'h00)
				s = {s, string'(h[i*8 +: 8])};
		return s;
	endfunction
	function automatic string dig(chan_rec_t c, logic [3:0] n);
		if (c.over_range)
			return c.is_current ? "0" : "9";
		return string'(8'h30 + {4'h0, n});
	endfunction
	function automatic string val(chan_rec_t c);
		string s;
		s = {string'(c.neg ? "-" : "+"), dig(c, c.mant[19:16]), "."};
		for (int i = 3; i >= 0; i--)
			s = {s, dig(c, c.mant[i*4 +: 4])};
		s = {s, "E", string'(c.exp_neg ? "-" : "+"), dig(c, c.expo[7:4])};
		return {s, dig(c, c.expo[3:0])};
	endfunction
	function automatic string rec(int f, logic cmp, int t);
		string s = "";
		for (int ch = 0; ch < `NUM_CH; ch++) begin
			if (ch > 0)
				s = {s, ","};
			s = {s, string'(8'h31 + 8'(ch))};
			if (f != 2)
				s = {s, ",", val(chan_data[ch])};
			if (f == 0)
				s = {s, ",", string'({5'h06, chan_data[ch].over_range,
					chan_data[ch].contact_err, 1'b0})};
			if (f != 1 && cmp)
				s = {s, ",", string'(chan_data[ch].above_hi ? "0" :
					chan_data[ch].below_lo ? "2" : "1")};
		end
		return t == 0 ? {s, "\n"} : t == 1 ? {s, "\r\n"} : s;
	endfunction
	task automatic rd(input string q, e);
		host.got = "";
		host.send(q, 1'b0);
		for (int i = 0; i < 3000 && host.got.len() < e.len(); i++)
			@(negedge sys_clk);
		repeat (30) @(negedge sys_clk);
		chks("record", e, host.got);
		chk("last eoi", 1, host.last_eoi);
	endtask
	task automatic ser(input string s);
		logic [9:0] f;
		for (int i = 0; i < s.len(); i++) begin
			f = {1'b1, s[i], 1'b0};
			for (int b = 0; b < 10; b++) begin
				@(negedge sys_clk);
				rxd = f[b];
				repeat (DIV - 1) @(negedge sys_clk);
			end
		end
		repeat (20) @(negedge sys_clk);
	endtask
	task automatic do_reset(input logic [4:0] a);
		@(negedge sys_clk);
		rst = 1'b1;
		addr_setting = a;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	initial begin
		for (int ch = 0; ch < `NUM_CH; ch++) begin
			chan_data[ch].mant = {4'(ch + 1), 16'h2345};
			chan_data[ch].expo = 8'h12;
			chan_data[ch].neg = ch[0];
			chan_data[ch].exp_neg = ch[1];
		end
		chan_data[1].over_range = 1'b1;
		chan_data[2].over_range = 1'b1;
		chan_data[2].is_current = 1'b1;
		chan_data[3].contact_err = 1'b1;
		chan_data[4].above_hi = 1'b1;
		chan_data[5].below_lo = 1'b1;
		do_reset(5'h07);
		chk("addr", 5'h07, gpib_addr);
		chk("remote off", 0, remote_en);
		addr_setting = 5'h1f;
		repeat (4) @(negedge sys_clk);
		chk("addr held", 5'h07, gpib_addr);
		do_reset(5'h1f);
		chk("addr low", 5'h01, gpib_addr);
		do_reset(5'h1e);
		chk("addr top", 5'h1e, gpib_addr);
		host.send("A?\r", 1'b0);
		host.send("B?\r\n", 1'b0);
		host.send("C?\n", 1'b0);
		host.send("D?", 1'b1);
		host.send("E 5;F?\n", 1'b0);
		repeat (4) @(negedge sys_clk);
		chk("strobes", 6, nstb);
		chk("queries", 5, nq);
		chk("arg", 8'h35, arg_seen);
		host.got = "";
		host.send({hs(`HDR_READ), " 1\n"}, 1'b0);
		repeat (20) @(negedge sys_clk);
		chk("bad query", 1, nerr);
		chks("no record", "", host.got);
		host.slow = 1'b1;
		rd({hs(`HDR_READ), "\n"}, rec(0, 1, 0));
		host.slow = 1'b0;
		for (int t = 1; t < 3; t++) begin
			host.send({hs(`HDR_DELIM), " ", string'(8'h30 + 8'(t)), "\n"}, 1'b0);
			rd({hs(`HDR_READ), "\n"}, rec(0, 1, t));
		end
		host.send({hs(`HDR_DELIM), " 0\n"}, 1'b0);
		cmp_enable = 1'b0;
		rd({hs(`HDR_READ), "\n"}, rec(0, 0, 0));
		cmp_enable = 1'b1;
		for (int f = 0; f < 3; f++) begin
			host.send({"FMT ", string'(8'h30 + 8'(f)), "\n"}, 1'b0);
			rd({hs(`HDR_TRIG), "\n"}, rec(f, 1, 0));
		end
		chk("triggers", 3, ntrig);
		n0 = nstb;
		ser("Q?\n");
		chk("serial locked", n0, nstb);
		ser({hs(`HDR_REMOTE), "\n"});
		chk("remote on", 1, remote_en);
		ser("Q?\n");
		chk("serial msg", n0 + 1, nstb);
		chk("serial hdr", 32'h0000513f, hdr_seen);
		sexp = rec(2, 1, 0);
		ser({hs(`HDR_READ), "\n"});
		for (int i = 0; i < 4000 && sgot.len() < sexp.len(); i++)
			@(negedge sys_clk);
		repeat (DIV * 12) @(negedge sys_clk);
		chks("serial record", sexp, sgot);
		complete_run();
	end
	initial begin
		#1500000;
		err_total++;
		complete_run();
	end
endmodule
